// *** shared/aac_pkg.sv ***
// aac_pkg: register map, field layout, reset values and types of the acquisition control block
// assumes an apb slave with 32-bit data, every register one aligned word
package aac_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CHANNEL = 8'h00; // channel select, r/w
    localparam logic [7:0] OFF_GAIN = 8'h04; // gain code, r/w
    localparam logic [7:0] OFF_MODE = 8'h08; // trigger mode, r/w
    localparam logic [7:0] OFF_INTCTL = 8'h0c; // interrupt source select, w; reads mode+source
    localparam logic [7:0] OFF_STATUS = 8'h10; // fifo / converter status, r
    localparam logic [7:0] OFF_DATA = 8'h14; // result pop: data and channel, r
    localparam logic [7:0] OFF_FIFO_RST = 8'h18; // fifo reset command, w
    localparam logic [7:0] OFF_SOFT_TRIG = 8'h1c; // software trigger, w
    localparam logic [7:0] OFF_INT_CLR = 8'h20; // bit0 clears line 1, bit1 line 2, w
    localparam logic [7:0] OFF_TIMER0 = 8'h24; // divider port 0 byte
    localparam logic [7:0] OFF_TIMER1 = 8'h28; // divider port 1 byte
    localparam logic [7:0] OFF_TIMER2 = 8'h2c; // divider port 2 byte
    localparam logic [7:0] OFF_INT_STAT = 8'h30; // latched interrupt requests, r

    // ------------------------------------------------------------------
    // field positions and widths
    // ------------------------------------------------------------------
    localparam int MODE_PACER_BIT = 0; // pacer trigger mode
    localparam int MODE_SOFT_BIT = 1; // software trigger mode
    localparam int MODE_SCAN_BIT = 2; // channel scan mode
    localparam int SECOND_INTERRUPT_LINE_SEL_BIT = 2; // line 2 select inside interrupt control
    localparam int RB_MODE_POS = 4; // mode field inside interrupt read-back
    localparam int ST_NOT_EMPTY = 0; // status bit positions
    localparam int ST_NOT_HALF = 1;
    localparam int ST_NOT_FULL = 2;
    localparam int ST_IDLE = 3;
    localparam int DATA_CH_POS = 16; // channel number beside result

    // ------------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------------
    localparam logic [1:0] GAIN_RESET = 2'h0; // code 0 = unity gain, widest range
    localparam logic [4:0] CHANNEL_RESET = 5'h00;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [1:0] FIRST_INTERRUPT_LINE_OFF = 2'h0; // line 1 disabled
    localparam logic [1:0] FIRST_INTERRUPT_LINE_EOC = 2'h1; // line 1 end of conversion
    localparam logic [1:0] FIRST_INTERRUPT_LINE_HALF = 2'h2; // line 1 fifo half full
    localparam logic [15:0] DIV_RESET = 16'h0000; // pacer stopped after reset

    // conversion time in ns and cycles at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_NS = 8000;
    localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // one converted sample headed for the fifo
    typedef struct packed {
        logic [4:0] channel; // converted channel
        logic [15:0] value; // bit 0 lsb, bit 15 msb
    } aac_sample_t;

    // converter sequencer states
    typedef enum logic [1:0] {
        AAC_IDLE = 2'b00,
        AAC_CONV = 2'b01,
        AAC_DONE = 2'b10
    } aac_state_t;

endpackage : aac_pkg

// *** design/aac_fifo.sv ***
// aac_fifo: synchronous result fifo with occupancy count and flush
// assumes writes never arrive when full; caller gates push with not-full
`timescale 1ns/1ps
`default_nettype none
module aac_fifo #(
    parameter int WIDTH = 21, // word width
    parameter int DEPTH = 1024 // words, power of two
) (
    input wire logic clk_sys, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic flush, // discard all contents
    input wire logic push, // write one word
    input wire logic [WIDTH-1:0] wdata, // word written
    input wire logic pop, // read one word
    output logic [WIDTH-1:0] rdata, // head word, valid while not empty
    output logic [$clog2(DEPTH):0] count // words held
);
    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("aac_fifo depth must be a power of two, at least 4");
    end

    logic [WIDTH-1:0] mem [DEPTH]; // storage, not reset
    logic [AW-1:0] wr_ptr; // next write slot
    logic [AW-1:0] rd_ptr; // head slot

    // ------------------------------------------------------------------
    // pointers and count; flush beats everything
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // storage write, no reset so it can map to ram
    always_ff @(posedge clk_sys) begin
        if (push && !flush) begin
            mem[wr_ptr] <= wdata;
        end
    end

    assign rdata = mem[rd_ptr]; // head word, combinational look-ahead
endmodule // aac_fifo
`default_nettype wire

// *** design/aac_ctrl.sv ***
// aac_ctrl: acquisition control - channel/scan, gain, trigger modes, pacer, result fifo, interrupts
// assumes an apb master on clk_sys; the converter is modelled by a fixed conversion time and adc_value input
//
// Operation
// - 32 inputs, channel register holds 0..31
// - no scan: channel register names input
// - scan: channel register is last channel
// - gain resets to unity, widest range
// - two-bit gain code, four gains
// - gain register reads back written code
// - status shows fifo not empty, not full
// - status shows not half full, idle
// - mode holds pacer, software, scan bits
// - mode register reads back current modes
// - interrupt control selects line sources
// - interrupt read-back returns mode and sources
// - results enter fifo in order; a result is dropped when the fifo is full or on a fifo reset
// - fifo reset command empties fifo
// - software trigger write starts one conversion
// - three timer ports, values 0..2
// - timer reads return low byte only
// - zero in either divider stops pacer
// - results 16 bits, bit0 lsb
// - line 1 off/eoc/half, line 2 off/pacer
// - requests latch until host clears
`timescale 1ns/1ps
`default_nettype none
module aac_ctrl #(
    parameter int FIFO_DEPTH = 1024, // result fifo words
    parameter int CONV_CYCLES = aac_pkg::CONV_CYCLES // conversion time in cycles
) (
    input wire logic clk_sys, // system clock, 100 MHz
    input wire logic rstn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address or write to read-only
    input wire logic [15:0] adc_value, // converter result, same clock
    output logic [4:0] mux_channel, // analog input in conversion
    output logic [1:0] gain_code, // gain select to front end
    output logic convert_start, // one-cycle conversion start
    output logic first_interrupt_line, // latched request line 1
    output logic second_interrupt_line // latched request line 2
);
    localparam int CW = $clog2(FIFO_DEPTH) + 1;

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (CONV_CYCLES < 1 || CONV_CYCLES > 65535) begin : g_bad_conv
        $error("aac_ctrl conversion count out of range");
    end

    // ------------------------------------------------------------------
    // all state in one struct
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [4:0] channel; // channel_select_value
        logic [1:0] gain; // gain code
        logic [2:0] mode; // scan, soft, pacer
        logic [1:0] first_interrupt_line_sel; // line 1 source
        logic second_interrupt_line_sel; // line 2 source
        logic [15:0] div1; // pacer first stage divider
        logic [15:0] div2; // pacer second stage divider
        logic [15:0] cnt1; // first stage count
        logic [15:0] cnt2; // second stage count
        logic [1:0][7:0] load_lo; // low byte staging for ports 1,2
        logic [2:0] byte_hi; // next byte is high, per port
        logic [4:0] scan_ch; // channel being converted in scan
        logic [4:0] mux; // channel on the analog mux, feeds the pin
        aac_pkg::aac_state_t state; // converter sequencer
        logic [15:0] conv_cnt; // conversion timer
        logic irq1; // latched line 1
        logic irq2; // latched line 2
        logic half_q; // half-full of previous cycle
        logic [31:0] rdata; // apb read data
        logic ready; // apb ready
        logic slverr; // apb error
        logic start; // conversion start pulse
    } aac_regs_t;

    aac_regs_t r; // registered state
    aac_regs_t next_r; // next state

    // fifo hook-up
    logic fifo_push; // completed conversion
    logic fifo_pop; // host data read
    logic fifo_flush; // reset command
    aac_pkg::aac_sample_t fifo_wdata; // sample written
    aac_pkg::aac_sample_t fifo_rdata; // head sample
    logic [CW-1:0] fifo_count; // occupancy

    logic not_empty; // fifo holds data
    logic not_full; // fifo has room
    logic not_half; // fifo below half occupancy
    logic apb_wr; // write access phase
    logic apb_rd; // read access phase
    logic pacer_tick; // pacer second stage expiry
    logic trigger; // any accepted trigger

    // ------------------------------------------------------------------
    // result fifo
    // ------------------------------------------------------------------
    aac_fifo #(
        .WIDTH($bits(aac_pkg::aac_sample_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .flush(fifo_flush),
        .push(fifo_push),
        .wdata(fifo_wdata),
        .pop(fifo_pop),
        .rdata(fifo_rdata),
        .count(fifo_count)
    );

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.ready = 1'b0;
        next_r.slverr = 1'b0;
        next_r.start = 1'b0;
        apb_wr = psel && penable && pwrite && !r.ready;
        apb_rd = psel && penable && !pwrite && !r.ready;
        not_empty = (fifo_count != '0);
        not_full = (fifo_count != CW'(FIFO_DEPTH));
        not_half = (fifo_count < CW'(FIFO_DEPTH / 2));
        fifo_flush = apb_wr && (paddr == aac_pkg::OFF_FIFO_RST);
        fifo_pop = apb_rd && (paddr == aac_pkg::OFF_DATA) && not_empty;
        fifo_push = 1'b0;
        fifo_wdata = '{channel: r.channel, value: adc_value};
        // pacer: two cascaded dividers, zero in either stops ticks
        pacer_tick = 1'b0;
        if (r.div1 == '0 || r.div2 == '0) begin
            next_r.cnt1 = '0;
            next_r.cnt2 = '0;
        end else if (r.cnt1 <= 16'h0001) begin
            next_r.cnt1 = r.div1;
            if (r.cnt2 <= 16'h0001) begin
                next_r.cnt2 = r.div2;
                pacer_tick = 1'b1;
            end else begin
                next_r.cnt2 = r.cnt2 - 16'h0001;
            end
        end else begin
            next_r.cnt1 = r.cnt1 - 16'h0001;
        end
        trigger = (pacer_tick && r.mode[aac_pkg::MODE_PACER_BIT])
            || (apb_wr && paddr == aac_pkg::OFF_SOFT_TRIG
                && r.mode[aac_pkg::MODE_SOFT_BIT]);
        // converter sequencer; triggers while busy are dropped
        case (r.state)
            aac_pkg::AAC_IDLE: begin
                if (trigger) begin
                    next_r.state = aac_pkg::AAC_CONV;
                    next_r.conv_cnt = 16'(CONV_CYCLES);
                    next_r.start = 1'b1;
                end
            end
            aac_pkg::AAC_CONV: begin
                if (r.conv_cnt <= 16'h0001) begin
                    next_r.state = aac_pkg::AAC_DONE;
                end else begin
                    next_r.conv_cnt = r.conv_cnt - 16'h0001;
                end
            end
            aac_pkg::AAC_DONE: begin
                fifo_push = not_full && !fifo_flush;
                fifo_wdata.channel = r.mux;
                // scan walks 0..last and wraps
                if (r.scan_ch >= r.channel) begin
                    next_r.scan_ch = '0;
                end else begin
                    next_r.scan_ch = r.scan_ch + 5'h01;
                end
                next_r.state = aac_pkg::AAC_IDLE;
            end
            default: begin
                next_r.state = aac_pkg::AAC_IDLE;
            end
        endcase
        // interrupts: set beats clear, no new request while latched
        next_r.half_q = !not_half;
        if (apb_wr && paddr == aac_pkg::OFF_INT_CLR && pwdata[0]) begin
            next_r.irq1 = 1'b0;
        end
        if (apb_wr && paddr == aac_pkg::OFF_INT_CLR && pwdata[1]) begin
            next_r.irq2 = 1'b0;
        end
        if ((r.first_interrupt_line_sel == aac_pkg::FIRST_INTERRUPT_LINE_EOC && fifo_push)
            || (r.first_interrupt_line_sel == aac_pkg::FIRST_INTERRUPT_LINE_HALF && !not_half && !r.half_q)) begin
            next_r.irq1 = 1'b1;
        end
        if (r.second_interrupt_line_sel && pacer_tick) begin
            next_r.irq2 = 1'b1;
        end
        // register writes
        if (apb_wr) begin
            next_r.ready = 1'b1;
            case (paddr)
                aac_pkg::OFF_CHANNEL: next_r.channel = pwdata[4:0];
                aac_pkg::OFF_GAIN: next_r.gain = pwdata[1:0];
                aac_pkg::OFF_MODE: begin
                    next_r.mode = pwdata[2:0];
                    next_r.scan_ch = '0;
                end
                aac_pkg::OFF_INTCTL: begin
                    next_r.first_interrupt_line_sel = pwdata[1:0];
                    next_r.second_interrupt_line_sel = pwdata[aac_pkg::SECOND_INTERRUPT_LINE_SEL_BIT];
                end
                aac_pkg::OFF_TIMER0, aac_pkg::OFF_FIFO_RST, aac_pkg::OFF_SOFT_TRIG,
                aac_pkg::OFF_INT_CLR: begin
                end
                aac_pkg::OFF_TIMER1: begin
                    // low byte then high byte
                    next_r.byte_hi[1] = !r.byte_hi[1];
                    if (r.byte_hi[1]) begin
                        next_r.div1 = {pwdata[7:0], r.load_lo[0]};
                        next_r.cnt1 = {pwdata[7:0], r.load_lo[0]};
                    end else begin
                        next_r.load_lo[0] = pwdata[7:0];
                    end
                end
                aac_pkg::OFF_TIMER2: begin
                    next_r.byte_hi[2] = !r.byte_hi[2];
                    if (r.byte_hi[2]) begin
                        next_r.div2 = {pwdata[7:0], r.load_lo[1]};
                        next_r.cnt2 = {pwdata[7:0], r.load_lo[1]};
                    end else begin
                        next_r.load_lo[1] = pwdata[7:0];
                    end
                end
                default: next_r.slverr = 1'b1; // unmapped or read-only
            endcase
        end
        // register reads
        if (apb_rd) begin
            next_r.ready = 1'b1;
            next_r.rdata = '0;
            case (paddr)
                aac_pkg::OFF_CHANNEL: next_r.rdata[4:0] = r.channel;
                aac_pkg::OFF_GAIN: next_r.rdata[1:0] = r.gain;
                aac_pkg::OFF_MODE: next_r.rdata[2:0] = r.mode;
                aac_pkg::OFF_INTCTL: begin
                    next_r.rdata[2:0] = {r.second_interrupt_line_sel, r.first_interrupt_line_sel};
                    next_r.rdata[aac_pkg::RB_MODE_POS +: 3] = r.mode;
                end
                aac_pkg::OFF_STATUS: begin
                    next_r.rdata[aac_pkg::ST_NOT_EMPTY] = not_empty;
                    next_r.rdata[aac_pkg::ST_NOT_HALF] = not_half;
                    next_r.rdata[aac_pkg::ST_NOT_FULL] = not_full;
                    next_r.rdata[aac_pkg::ST_IDLE] = (r.state == aac_pkg::AAC_IDLE);
                end
                aac_pkg::OFF_DATA: begin
                    // empty fifo reads as zero
                    if (not_empty) begin
                        next_r.rdata[15:0] = fifo_rdata.value;
                        next_r.rdata[aac_pkg::DATA_CH_POS +: 5] = fifo_rdata.channel;
                    end
                end
                aac_pkg::OFF_TIMER0: next_r.rdata = '0;
                aac_pkg::OFF_TIMER1: next_r.rdata[7:0] = r.cnt1[7:0];
                aac_pkg::OFF_TIMER2: next_r.rdata[7:0] = r.cnt2[7:0];
                aac_pkg::OFF_INT_STAT: next_r.rdata[1:0] = {r.irq2, r.irq1};
                default: next_r.slverr = 1'b1;
            endcase
        end
        // mux select kept in a flop so the pin never glitches on a mode write
        if (next_r.mode[aac_pkg::MODE_SCAN_BIT]) begin
            next_r.mux = next_r.scan_ch;
        end else begin
            next_r.mux = next_r.channel;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
            r.gain <= aac_pkg::GAIN_RESET;
            r.channel <= aac_pkg::CHANNEL_RESET;
            r.mode <= aac_pkg::MODE_RESET;
            r.div1 <= aac_pkg::DIV_RESET;
            r.div2 <= aac_pkg::DIV_RESET;
            r.state <= aac_pkg::AAC_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------------
    assign prdata = r.rdata;
    assign pready = r.ready;
    assign pslverr = r.slverr;
    // scan uses walking channel, otherwise the held one
    assign mux_channel = r.mux;
    assign gain_code = r.gain;
    assign convert_start = r.start;
    assign first_interrupt_line = r.irq1;
    assign second_interrupt_line = r.irq2;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_scan_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.state == aac_pkg::AAC_DONE && r.scan_ch >= r.channel && !apb_wr) |=> r.scan_ch == '0)
        else $error("scan channel did not wrap");
    a_gain_reset: assert property (@(posedge clk_sys) $rose(rstn) |-> gain_code == aac_pkg::GAIN_RESET)
        else $error("gain not unity after reset");
    a_gain_readback: assert property (@(posedge clk_sys) disable iff (!rstn)
        (apb_rd && paddr == aac_pkg::OFF_GAIN) |=> prdata[1:0] == gain_code && pready)
        else $error("gain read-back wrong");
    a_status_empty: assert property (@(posedge clk_sys) disable iff (!rstn)
        (apb_rd && paddr == aac_pkg::OFF_STATUS) |=> prdata[aac_pkg::ST_NOT_EMPTY] == ($past(fifo_count) != '0))
        else $error("not-empty flag wrong");
    a_idle_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
        (apb_rd && paddr == aac_pkg::OFF_STATUS && r.state != aac_pkg::AAC_IDLE)
        |=> !prdata[aac_pkg::ST_IDLE])
        else $error("idle shown while converting");
    a_flush_empty: assert property (@(posedge clk_sys) disable iff (!rstn)
        fifo_flush |=> fifo_count == '0)
        else $error("fifo not empty after reset command");
    a_soft_start: assert property (@(posedge clk_sys) disable iff (!rstn)
        (apb_wr && paddr == aac_pkg::OFF_SOFT_TRIG && r.mode[aac_pkg::MODE_SOFT_BIT]
         && r.state == aac_pkg::AAC_IDLE) |=> convert_start)
        else $error("software trigger gave no start");
    a_pacer_stop: assert property (@(posedge clk_sys) disable iff (!rstn)
        (r.div1 == '0 || r.div2 == '0) |-> !pacer_tick)
        else $error("pacer ticked with zero divider");
    a_irq_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        (first_interrupt_line && !(apb_wr && paddr == aac_pkg::OFF_INT_CLR)) |=> first_interrupt_line)
        else $error("line 1 request dropped without clear");
    a_timer_byte: assert property (@(posedge clk_sys) disable iff (!rstn)
        (apb_rd && (paddr == aac_pkg::OFF_TIMER1 || paddr == aac_pkg::OFF_TIMER2)) |=> prdata[31:8] == '0)
        else $error("timer read wider than a byte");
    c_push: cover property (@(posedge clk_sys) disable iff (!rstn) fifo_push);
    c_scan_wrap: cover property (@(posedge clk_sys) disable iff (!rstn)
        r.state == aac_pkg::AAC_DONE && r.scan_ch != '0 && r.scan_ch >= r.channel);
    c_irq1: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(first_interrupt_line));
    c_pacer: cover property (@(posedge clk_sys) disable iff (!rstn) pacer_tick);
endmodule // aac_ctrl
`default_nettype wire

// *** dv/aac_adc_model.sv ***
// aac_adc_model: converter stand-in that answers convert_start
// assumes the result is sampled within cv+1 cycles of the start pulse
`timescale 1ns/1ps
`default_nettype none
module aac_adc_model #(
    parameter int CV = 5 // conversion cycles
) (
    input wire logic clk_sys, // system clock
    input wire logic rstn, // async reset, active low
    input wire logic convert_start, // start pulse
    input wire logic [4:0] mux_channel, // channel under conversion
    output logic [15:0] adc_value // result
);
    logic [15:0] v; // held result
    int k; // hold window left
    // result tags the channel; outside the window the inverse shows
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            k <= 0;
            v <= 16'h0000;
        end else if (convert_start) begin
            k <= CV + 2;
            v <= {8'ha5, 3'h0, mux_channel};
        end else if (k != 0) begin
            k <= k - 1;
        end
    end
    assign adc_value = (k != 0) ? v : ~v;
endmodule // aac_adc_model
`default_nettype wire

// *** dv/adc_acquisition_control_tb.sv ***
// adc_acquisition_control_tb: apb master, queue model, checks
// assumes one wait state answers and conversions of 5 cycles
`timescale 1ns/1ps
`default_nettype none
module adc_acquisition_control_tb;
    logic clk_sys = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, cs, i1, i2;
    logic [15:0] av;
    logic [4:0] mc;
    logic [1:0] gc;
    int errors = 0, n_checks = 0, ch, g;
    logic [31:0] q[$]; // expected fifo words
    always #5 clk_sys = ~clk_sys;
    aac_ctrl #(.FIFO_DEPTH(8), .CONV_CYCLES(5)) dut_u (.clk_sys(clk_sys), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_value(av), .mux_channel(mc),
        .gain_code(gc), .convert_start(cs), .first_interrupt_line(i1), .second_interrupt_line(i2));
    aac_adc_model #(.CV(5)) adc_u (.clk_sys(clk_sys), .rstn(rstn), .convert_start(cs),
        .mux_channel(mc), .adc_value(av));
    // apb transfer, held until pready is seen
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys) penable <= 1;
        // no cycle limit here: only the watchdog ends a hung wait
        do begin @(posedge clk_sys); end while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
        @(posedge clk_sys);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // soft trigger; model predicts the stored word
    task automatic trig(input int c);
        bus(1, aac_pkg::OFF_SOFT_TRIG, 0);
        q.push_back({11'h0, c[4:0], 8'ha5, 3'h0, c[4:0]});
        repeat (12) @(posedge clk_sys);
    endtask
    task automatic wrap_up;
        if (errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        wrap_up;
    end
    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        void'($urandom(21));
        repeat (12) @(posedge clk_sys);
        rstn <= 1;
        @(posedge clk_sys);
        bus(0, aac_pkg::OFF_GAIN, 0); chk(rd, 0);
        for (int i = 0; i < 4; i++) begin
            g = $urandom % 4;
            bus(1, aac_pkg::OFF_GAIN, g);
            bus(0, aac_pkg::OFF_GAIN, 0); chk(rd, g);
            chk({30'h0, gc}, g);
        end
        bus(1, aac_pkg::OFF_FIFO_RST, 0);
        bus(0, aac_pkg::OFF_STATUS, 0); chk(rd, 32'he);
        bus(0, 8'hfc, 0); chk({31'h0, er}, 1);
        bus(0, aac_pkg::OFF_TIMER0, 0); chk(rd, 0);
        bus(1, aac_pkg::OFF_INTCTL, 1);
        bus(1, aac_pkg::OFF_MODE, 2);
        bus(0, aac_pkg::OFF_MODE, 0); chk(rd, 2);
        bus(0, aac_pkg::OFF_INTCTL, 0); chk(rd, 32'h21);
        ch = $urandom % 32;
        bus(1, aac_pkg::OFF_CHANNEL, ch);
        bus(0, aac_pkg::OFF_CHANNEL, 0); chk(rd, ch);
        trig(ch); trig(ch);
        chk({31'h0, i1}, 1);
        bus(1, aac_pkg::OFF_INT_CLR, 1);
        chk({31'h0, i1}, 0);
        bus(1, aac_pkg::OFF_MODE, 6);
        bus(1, aac_pkg::OFF_CHANNEL, 2);
        for (int i = 0; i < 4; i++) trig(i % 3);
        while (q.size() > 0) begin
            bus(0, aac_pkg::OFF_DATA, 0); chk(rd, q.pop_front());
        end
        bus(0, aac_pkg::OFF_STATUS, 0); chk(rd, 32'he);
        // pacer 2 x 3 cycles drives line 2; no pacer mode bit, so no conversions
        bus(1, aac_pkg::OFF_INTCTL, 4);
        bus(1, aac_pkg::OFF_TIMER1, 2);
        bus(1, aac_pkg::OFF_TIMER1, 0);
        bus(1, aac_pkg::OFF_TIMER2, 3);
        bus(1, aac_pkg::OFF_TIMER2, 0);
        repeat (20) @(posedge clk_sys);
        chk({31'h0, i2}, 1);
        bus(0, aac_pkg::OFF_TIMER2, 0);
        chk(rd & 32'hffffff00, 0);
        // zero in the first stage stops ticks, so a cleared line stays low
        bus(1, aac_pkg::OFF_TIMER1, 0);
        bus(1, aac_pkg::OFF_TIMER1, 0);
        bus(1, aac_pkg::OFF_INT_CLR, 2);
        repeat (20) @(posedge clk_sys);
        chk({31'h0, i2}, 0);
        wrap_up;
    end
endmodule // adc_acquisition_control_tb
`default_nettype wire
